// ===== jtp_pkg.sv
// jtp_pkg: constants and types for the test access port
// assumes: one system clock; all pins are sampled into that domain
package jtp_pkg;
  localparam int IR_W = 6;
  localparam int BYP_W = 1;
  localparam int ID_W = 32;
  localparam int BIST_W = 1;
  localparam int BSR_W = 159;
  localparam int TLR_TMS_CNT = 5;
  localparam logic [2:0] TMS_CNT_MAX = 3'h5;
  localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;
  localparam logic [IR_W-1:0] OP_EXTEST = 6'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE = 6'h01;
  localparam logic [IR_W-1:0] OP_IDCODE = 6'h02;
  localparam logic [IR_W-1:0] OP_CLAMP = 6'h04;
  localparam logic [IR_W-1:0] OP_RUNBIST = 6'h07;
  localparam logic [IR_W-1:0] OP_HIGHZ = 6'h08;
  localparam logic [IR_W-1:0] OP_BYPASS = 6'h3F;
  localparam logic [IR_W-1:0] IR_RST_VAL = OP_IDCODE;
  localparam logic BYP_CAPTURE = 1'h0;
  localparam logic TDO_RST_VAL = 1'h0;
  localparam logic [3:0] PIN_SYNC_RST = 4'h0;

  typedef enum {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } jtp_state_t;

  typedef enum {DR_BSR, DR_ID, DR_BIST, DR_BYP} jtp_dr_t;
endpackage

// ===== jtp_link_if.sv
// jtp_link_if: sampled test pins and test clock edge strobes
// assumes: driven by jtp_pin_sync, read by the port core, same clock
`timescale 1ns/1ps
interface jtp_link_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst_act;
  modport sync (output tck_rise, tck_fall, tms, tdi, trst_act);
  modport core (input tck_rise, tck_fall, tms, tdi, trst_act);
endinterface

// ===== jtp_pin_sync.sv
// jtp_pin_sync: two-stage pin synchroniser and test clock edge finder
// assumes: test clock much slower than clk_i (at least 4 cycles a phase)
`timescale 1ns/1ps
module jtp_pin_sync
  import jtp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  jtp_link_if.sync lnk
);
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic tck_d_ff;

  // bit 3 test clock, 2 mode select, 1 data in, 0 reset (low active)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= PIN_SYNC_RST;
      s2_ff <= PIN_SYNC_RST;
      tck_d_ff <= 1'b0;
    end else begin
      s1_ff <= {tck_i, tms_i, tdi_i, trst_n_i};
      s2_ff <= s1_ff;
      tck_d_ff <= s2_ff[3];
    end
  end

  // mode and data are stable around the edge, so same-stage samples suffice
  assign lnk.tck_rise = s2_ff[3] & ~tck_d_ff;
  assign lnk.tck_fall = ~s2_ff[3] & tck_d_ff;
  assign lnk.tms = s2_ff[2];
  assign lnk.tdi = s2_ff[1];
  assign lnk.trst_act = ~s2_ff[0];
endmodule

// ===== jtp_shreg.sv
// jtp_shreg: capture/shift stage with a parallel update latch
// assumes: strobes are one-cycle pulses, never two at once
`timescale 1ns/1ps
module jtp_shreg #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic cap_i,
  input wire logic shift_i,
  input wire logic upd_i,
  input wire logic tdi_i,
  input wire logic [W-1:0] pdata_i,
  output logic [W-1:0] sreg_o,
  output logic [W-1:0] latch_o
);
  // msb fed from serial input, lsb is the serial output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sreg_o <= '0;
    end else if (cap_i) begin
      sreg_o <= pdata_i;
    end else if (shift_i) begin
      sreg_o <= {tdi_i, sreg_o[W-1:1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      latch_o <= RST_VAL;
    end else if (upd_i) begin
      latch_o <= sreg_o;
    end
  end
endmodule

// ===== jtp_tap_ctrl.sv
// jtp_tap_ctrl: boundary-scan test access port core
// assumes: test pins asynchronous to CLK_I, test clock slow against it
`timescale 1ns/1ps
module jtp_tap_ctrl
  import jtp_pkg::*;
#(
  // arbitrary value; bit 0 must stay 1
  parameter logic [ID_W-1:0] ID_CODE = 32'h0000_0001
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic TCK_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  input wire logic TRST_N_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  input wire logic [BSR_W-1:0] BSR_PIN_I,
  output logic [BSR_W-1:0] BSR_OUT_O,
  input wire logic BIST_FAIL_I,
  output logic BIST_START_O,
  output logic [IR_W-1:0] INSTR_O,
  output logic PINS_FROM_BSR_O,
  output logic PINS_FLOAT_O,
  output logic TEST_RESET_O
);
  jtp_link_if lnk();

  jtp_state_t state_ff;
  jtp_state_t nxt_state;
  jtp_dr_t dr_sel;
  logic [IR_W-1:0] ir_sreg;
  logic [IR_W-1:0] ir_latch;
  logic [BSR_W-1:0] bsr_sreg;
  logic [ID_W-1:0] id_ff;
  logic byp_ff;
  logic bist_ff;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic bist_start_ff;
  logic pins_bsr_ff;
  logic pins_float_ff;
  logic rise;
  logic fall;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic ser_out;
  logic [2:0] tms_cnt;

  // graph of the controller
  function automatic jtp_state_t next_of(jtp_state_t st, logic tms);
    jtp_state_t ns;
    ns = ST_TLR;
    case (st)
      ST_TLR: ns = tms ? ST_TLR : ST_RTI;
      ST_RTI: ns = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: ns = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: ns = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: ns = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: ns = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: ns = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: ns = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: ns = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: ns = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: ns = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: ns = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: ns = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: ns = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: ns = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: ns = tms ? ST_SEL_DR : ST_RTI;
      default: ns = ST_TLR;
    endcase
    return ns;
  endfunction

  // opcode decode
  // reserved patterns fall back to bypass so the chain stays one bit
  function automatic jtp_dr_t dr_of(logic [IR_W-1:0] op);
    jtp_dr_t d;
    d = DR_BYP;
    case (op)
      OP_EXTEST, OP_SAMPLE: d = DR_BSR;
      OP_IDCODE: d = DR_ID;
      OP_RUNBIST: d = DR_BIST;
      default: d = DR_BYP;
    endcase
    return d;
  endfunction

  function automatic logic in_shift(jtp_state_t st);
    return (st == ST_SH_DR) || (st == ST_SH_IR);
  endfunction

  // pins sampled into the system clock
  jtp_pin_sync u_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tck_i(TCK_I),
    .tms_i(TMS_I),
    .tdi_i(TDI_I),
    .trst_n_i(TRST_N_I),
    .lnk(lnk.sync)
  );

  assign rise = lnk.tck_rise;
  assign fall = lnk.tck_fall;
  assign nxt_state = next_of(state_ff, lnk.tms);

  // reset entry, held while test reset active
  // moves only on a rising test clock edge
  always_ff @(posedge CLK_I) begin
    if (RST_I || lnk.trst_act) begin
      state_ff <= ST_TLR;
    end else if (rise) begin
      state_ff <= nxt_state;
    end
  end

  // latch forced to identification in the reset state
  jtp_shreg #(.W(IR_W), .RST_VAL(IR_RST_VAL)) u_ir (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .clr_i(state_ff == ST_TLR),
    .cap_i(rise && state_ff == ST_CAP_IR),
    .shift_i(rise && state_ff == ST_SH_IR),
    .upd_i(fall && state_ff == ST_UPD_IR),
    .tdi_i(lnk.tdi),
    .pdata_i(IR_CAPTURE),
    .sreg_o(ir_sreg),
    .latch_o(ir_latch)
  );

  // selected data register from the latch only
  assign dr_sel = dr_of(ir_latch);
  // capture and shift only in their own states
  assign cap_dr = rise && state_ff == ST_CAP_DR;
  assign sh_dr = rise && state_ff == ST_SH_DR;
  assign upd_dr = fall && state_ff == ST_UPD_DR;

  jtp_shreg #(.W(BSR_W), .RST_VAL('0)) u_bsr (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .clr_i(1'b0),
    .cap_i(cap_dr && dr_sel == DR_BSR),
    .shift_i(sh_dr && dr_sel == DR_BSR),
    .upd_i(upd_dr && dr_sel == DR_BSR),
    .tdi_i(lnk.tdi),
    .pdata_i(BSR_PIN_I),
    .sreg_o(bsr_sreg),
    .latch_o(BSR_OUT_O)
  );

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      byp_ff <= BYP_CAPTURE;
    end else if (cap_dr && dr_sel == DR_BYP) begin
      byp_ff <= BYP_CAPTURE;
    end else if (sh_dr && dr_sel == DR_BYP) begin
      byp_ff <= lnk.tdi;
    end
  end

  // identification register, capture and shift, no latch
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      id_ff <= ID_CODE;
    end else if (cap_dr && dr_sel == DR_ID) begin
      id_ff <= ID_CODE;
    end else if (sh_dr && dr_sel == DR_ID) begin
      id_ff <= {lnk.tdi, id_ff[ID_W-1:1]};
    end
  end

  // self-test result; zero means pass
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bist_ff <= 1'b0;
    end else if (cap_dr && dr_sel == DR_BIST) begin
      bist_ff <= BIST_FAIL_I;
    end else if (sh_dr && dr_sel == DR_BIST) begin
      bist_ff <= lnk.tdi;
    end
  end

  // self-test kicked on each idle clock; it is not stopped on leaving idle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bist_start_ff <= 1'b0;
    end else begin
      bist_start_ff <= rise && state_ff == ST_RTI && ir_latch == OP_RUNBIST;
    end
  end

  always_comb begin
    case (dr_sel)
      DR_BSR: ser_out = bsr_sreg[0];
      DR_ID: ser_out = id_ff[0];
      DR_BIST: ser_out = bist_ff;
      default: ser_out = byp_ff;
    endcase
    if (state_ff == ST_SH_IR) begin
      ser_out = ir_sreg[0];
    end
  end

  // change on falling edges; test reset floats at once
  always_ff @(posedge CLK_I) begin
    if (RST_I || lnk.trst_act) begin
      tdo_ff <= TDO_RST_VAL;
      tdo_oe_ff <= 1'b0;
    end else if (fall) begin
      tdo_ff <= ser_out;
      tdo_oe_ff <= in_shift(state_ff);
    end
  end

  // pin control off in reset; latch already forced there
  always_ff @(posedge CLK_I) begin
    if (RST_I || state_ff == ST_TLR) begin
      pins_bsr_ff <= 1'b0;
      pins_float_ff <= 1'b0;
    end else begin
      pins_bsr_ff <= ir_latch == OP_EXTEST || ir_latch == OP_CLAMP ||
                     ir_latch == OP_RUNBIST;
      pins_float_ff <= ir_latch == OP_HIGHZ;
    end
  end

  assign TDO_O = tdo_ff;
  assign TDO_OE_O = tdo_oe_ff;
  assign BIST_START_O = bist_start_ff;
  assign INSTR_O = ir_latch;
  assign PINS_FROM_BSR_O = pins_bsr_ff;
  assign PINS_FLOAT_O = pins_float_ff;
  assign TEST_RESET_O = state_ff == ST_TLR;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tms_cnt <= 3'h0;
    end else if (rise) begin
      if (!lnk.tms) begin
        tms_cnt <= 3'h0;
      end else if (tms_cnt != TMS_CNT_MAX) begin
        tms_cnt <= tms_cnt + 3'h1;
      end
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  trst_hold_a: assert property (
    lnk.trst_act |=> state_ff == ST_TLR)
    else $error("test reset did not hold reset state");

  tms_five_a: assert property (
    tms_cnt == TMS_CNT_MAX |-> state_ff == ST_TLR)
    else $error("five mode-high edges did not reach reset state");

  fsm_edge_a: assert property (
    !rise && !lnk.trst_act |=> $stable(state_ff))
    else $error("controller moved without a rising edge");

  fsm_step_a: assert property (
    rise && !lnk.trst_act |=> state_ff == $past(nxt_state))
    else $error("controller left the graph");

  tlr_idcode_a: assert property (
    state_ff == ST_TLR |=> INSTR_O == OP_IDCODE)
    else $error("reset state did not force identification");

  ir_capture_a: assert property (
    rise && state_ff == ST_CAP_IR |=> ir_sreg == IR_CAPTURE
      && $stable(ir_latch))
    else $error("capture-ir value wrong");

  ir_shift_a: assert property (
    rise && state_ff == ST_SH_IR |=>
      ir_sreg == {$past(lnk.tdi), $past(ir_sreg[IR_W-1:1])})
    else $error("instruction shift wrong");

  ir_latch_a: assert property (
    state_ff != ST_UPD_IR && state_ff != ST_TLR |=> $stable(ir_latch))
    else $error("instruction changed outside update");

  ir_update_a: assert property (
    fall && state_ff == ST_UPD_IR |=> ir_latch == $past(ir_sreg))
    else $error("instruction not latched in update");

  bypass_sel_a: assert property (
    INSTR_O == OP_BYPASS |-> dr_sel == DR_BYP)
    else $error("all-ones did not select bypass");

  pause_hold_a: assert property (
    state_ff inside {ST_PA_IR, ST_PA_DR} |=> $stable(ir_sreg)
      && $stable(bsr_sreg) && $stable(id_ff))
    else $error("shift path moved in a pause state");

  dr_hold_a: assert property (
    state_ff inside {ST_RTI, ST_SEL_DR, ST_SEL_IR, ST_EX1_DR, ST_PA_DR,
      ST_EX2_DR} |=> $stable(bsr_sreg) && $stable(id_ff)
      && $stable(byp_ff) && $stable(bist_ff))
    else $error("data register changed in a hold state");

  bsr_latch_a: assert property (
    state_ff != ST_UPD_DR |=> $stable(BSR_OUT_O))
    else $error("boundary latch changed outside update-dr");

  bypass_zero_a: assert property (
    cap_dr && dr_sel == DR_BYP |=> byp_ff == 1'b0)
    else $error("bypass did not capture zero");

  tdo_enable_a: assert property (
    fall && !lnk.trst_act |=> TDO_OE_O == in_shift($past(state_ff)))
    else $error("data out enable wrong");

  trst_quiet_a: assert property (
    lnk.trst_act |=> !TDO_OE_O)
    else $error("data out driven under test reset");

  tdo_quiet_a: assert property (
    state_ff == ST_RTI && !fall |=> !TDO_OE_O)
    else $error("data out driven while idle");

  ir_bypass_c: cover property (
    fall && state_ff == ST_UPD_IR && ir_sreg == OP_BYPASS);
  id_shift_c: cover property (sh_dr && dr_sel == DR_ID);
  pause_dr_c: cover property (
    rise && state_ff == ST_PA_DR ##[1:200] rise && state_ff == ST_SH_DR);
  trst_c: cover property (lnk.trst_act && state_ff == ST_SH_DR);
endmodule

// ===== jtp_tester.sv
// jtp_tester: boundary-scan tester on the far side of the test pins
// assumes: caller steps one test clock at a time; clock idles low
`timescale 1ns/1ps
module jtp_tester (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  logic last_tdo;

  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
    trst_n_o = 1'h1;
    last_tdo = 1'h0;
  end

  // pins change only in the low phase
  // 37 ns offset keeps test clock edges off the system clock edges
  task automatic step(input logic tms, input logic tdi, output logic tdo,
                      output logic oe);
    tms_o = tms;
    tdi_o = tdi;
    #37;
    // released line has no pull: show the inverse of the last level
    tdo = tdo_oe_i ? tdo_i : ~last_tdo;
    oe = tdo_oe_i;
    last_tdo = tdo;
    tck_o = 1'h1;
    #80;
    tck_o = 1'h0;
    #43;
  endtask

  task automatic set_trst(input logic v);
    trst_n_o = v;
  endtask
endmodule

// ===== jtp_tap_ctrl_tb.sv
// jtp_tap_ctrl_tb: self-checking bench for the test access port
// assumes: jtp_tester drives the pins; 100 MHz system clock
`timescale 1ns/1ps
module jtp_tap_ctrl_tb;
  import jtp_pkg::*;
  // arbitrary identification value; bit 0 must stay 1
  localparam logic [ID_W-1:0] TB_ID = 32'h5A3C_96E1;
  localparam int XTRA = 8;
  localparam logic H = 1'h1;
  localparam logic L = 1'h0;
  logic clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, bist_fail, bist_start;
  logic pins_bsr, pins_float, test_rst;
  logic [BSR_W-1:0] bsr_pin, bsr_out, exp_bsr;
  logic [IR_W-1:0] instr;
  logic [IR_W-1:0] ops [8];
  int failures = 0;
  int compares = 0;
  int bist_cnt = 0;

  jtp_tap_ctrl #(.ID_CODE(TB_ID)) i_jtp_tap_ctrl (.CLK_I(clk), .RST_I(rst),
    .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TRST_N_I(trst_n), .TDO_O(tdo),
    .TDO_OE_O(tdo_oe), .BSR_PIN_I(bsr_pin), .BSR_OUT_O(bsr_out),
    .BIST_FAIL_I(bist_fail), .BIST_START_O(bist_start), .INSTR_O(instr),
    .PINS_FROM_BSR_O(pins_bsr), .PINS_FLOAT_O(pins_float),
    .TEST_RESET_O(test_rst));
  jtp_tester i_jtp_tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .trst_n_o(trst_n), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (bist_start === 1'h1) bist_cnt <= bist_cnt + 1;

  task automatic chk(input logic [166:0] got, input logic [166:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tk(input logic m, input logic d);
    logic q, o;
    i_jtp_tester.step(m, d, q, o);
  endtask

  function automatic int dr_len(input logic [IR_W-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE: return BSR_W;
      OP_IDCODE: return ID_W;
      default: return 1;
    endcase
  endfunction

  // bypass and reserved codes capture zero
  function automatic logic [166:0] dr_cap(input logic [IR_W-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE: return 167'(bsr_pin);
      OP_IDCODE: return 167'(TB_ID);
      OP_RUNBIST: return 167'(bist_fail);
      default: return '0;
    endcase
  endfunction

  task automatic ir_scan(input logic [IR_W-1:0] op);
    logic [IR_W-1:0] cap, prev;
    logic d, o, oe_all;
    prev = instr;
    oe_all = 1'h1;
    tk(H, L);
    tk(H, L);
    tk(L, L);
    tk(L, L);
    for (int i = 0; i < IR_W; i++) begin
      i_jtp_tester.step(i == IR_W - 1, op[i], d, o);
      cap[i] = d;
      oe_all &= o;
    end
    chk(cap, 6'h01);
    chk(oe_all, 1'h1);
    chk(instr, prev);
    tk(H, L);
    tk(L, L);
    chk(instr, op);
    chk(tdo_oe, 1'h0);
  endtask

  // pause after the fourth bit; random data there must not shift in
  task automatic dr_scan(input int w, input logic [166:0] din,
                         output logic [166:0] dout);
    logic d, o;
    dout = '0;
    tk(H, L);
    tk(L, L);
    tk(L, L);
    for (int i = 0; i < w + XTRA; i++) begin
      i_jtp_tester.step(i == w + XTRA - 1 || i == 3, din[i], d, o);
      dout[i] = d;
      if (i == 3) begin
        tk(L, 1'($urandom));
        tk(L, 1'($urandom));
        tk(H, 1'($urandom));
        tk(L, 1'($urandom));
      end
    end
    chk(bsr_out, exp_bsr);
    tk(H, L);
    tk(L, L);
  endtask

  initial begin
    #400000;
    failures++;
    $display("watchdog expired at %0t ns", $time);
    give_verdict();
  end

  initial begin
    int w, n;
    logic [166:0] din, dout;
    rst = 1'h1;
    bsr_pin = '0;
    bist_fail = 1'h0;
    exp_bsr = '0;
    ops = '{OP_EXTEST, OP_SAMPLE, OP_IDCODE, OP_CLAMP, OP_RUNBIST, OP_HIGHZ,
            OP_BYPASS, 6'h15};
    void'($urandom(15));
    repeat (3) @(negedge clk);
    rst = 1'h0;
    repeat (6) @(negedge clk);
    chk(test_rst, 1'h1);
    chk(instr, 6'h02);
    chk(tdo_oe, 1'h0);
    tk(L, L);
    chk(test_rst, 1'h0);
    $display("test power-up reset done");
    foreach (ops[k]) begin
      @(negedge clk);
      for (int b = 0; b < BSR_W; b++) bsr_pin[b] = 1'($urandom);
      for (int b = 0; b < 167; b++) din[b] = 1'($urandom);
      bist_fail = 1'($urandom);
      ir_scan(ops[k]);
      chk(pins_bsr, ops[k] inside {6'h00, 6'h04, 6'h07});
      chk(pins_float, ops[k] == 6'h08);
      n = bist_cnt;
      tk(L, L);
      chk(bist_cnt != n, ops[k] == 6'h07);
      w = dr_len(ops[k]);
      dr_scan(w, din, dout);
      chk(dout, (167'(din[XTRA-1:0]) << w) | dr_cap(ops[k]));
      if (ops[k] inside {6'h00, 6'h01}) exp_bsr = din[XTRA +: BSR_W];
      chk(bsr_out, exp_bsr);
      $display("test opcode %h done", ops[k]);
    end
    ir_scan(OP_BYPASS);
    tk(H, L);
    tk(L, L);
    tk(L, L);
    for (int i = 1; i <= 5; i++) begin
      tk(H, L);
      if (i == 4) chk(test_rst, 1'h0);
    end
    chk(test_rst, 1'h1);
    chk(instr, 6'h02);
    tk(L, L);
    $display("test mode reset done");
    ir_scan(OP_BYPASS);
    tk(H, L);
    tk(L, L);
    tk(L, L);
    i_jtp_tester.set_trst(1'h0);
    repeat (5) @(negedge clk);
    chk(test_rst, 1'h1);
    chk(instr, 6'h02);
    tk(L, L);
    tk(L, L);
    chk(test_rst, 1'h1);
    i_jtp_tester.set_trst(1'h1);
    repeat (6) @(negedge clk);
    tk(L, L);
    chk(test_rst, 1'h0);
    $display("test pin reset done");
    give_verdict();
  end
endmodule
